// file: verilog/profile_pkg.sv
package profile_pkg;
    localparam int NGEN = 8;
    localparam int NCH  = 8;
    localparam int NSEC = 100;
    localparam int VW   = 16;
    localparam int DW   = 32;
    localparam int AW   = 13;

    // evaluation tick of 0.1 s
    localparam int CLK_HZ     = 100_000_000;
    localparam int TICK_MS    = 100;
    localparam int TICK_CYC   = CLK_HZ / 1000 * TICK_MS;
    localparam int TICKS_SEC  = 1000 / TICK_MS;
    localparam int TICKS_MIN  = 60 * TICKS_SEC;
    localparam int TICKS_HOUR = 3600 * TICKS_SEC;

    // word address map
    localparam int SEC_BIT     = 12;
    localparam int SEC_GEN_LSB = 8;
    localparam int SEC_IDX_LSB = 1;
    localparam int CFG_GEN_LSB = 4;
    localparam logic [3:0] REG_CTRL   = 4'h0;
    localparam logic [3:0] REG_IDLE   = 4'h1;
    localparam logic [3:0] REG_LIST   = 4'h2;
    localparam logic [3:0] REG_LOOPS  = 4'h3;
    localparam logic [3:0] REG_TOD    = 4'h4;
    localparam logic [3:0] REG_STATUS = 4'h5;
    localparam logic [3:0] REG_OUT    = 4'h6;

    // field positions
    localparam int CTL_TRIG  = 0;
    localparam int CTL_PAUSE = 4;
    localparam int CTL_LOOP  = 8;
    localparam int CTL_TSRC  = 12;
    localparam int CTL_PSRC  = 16;
    localparam int CTL_LSRC  = 20;
    localparam int LST_RST   = 8;
    localparam int TOD_MIN   = 8;
    localparam int TOD_HOUR  = 16;
    localparam int STA_PAUSE = 1;
    localparam int STA_IDX   = 8;
    localparam int STA_CYC   = 16;
    localparam int SEC_UNIT  = 16;
    localparam int SEC_SLOPE = 20;
    localparam logic [DW-1:0] RD_RST = 32'h0;

    typedef enum logic [2:0] {TRG_OFF, TRG_GATE, TRG_ONCE, TRG_RETRIG, TRG_TOD} trig_e;
    typedef enum logic [2:0] {PS_OFF, PS_HIGH, PS_LOW, PS_RISE, PS_FALL} pause_e;
    typedef enum logic [1:0] {LP_OFF, LP_COUNT, LP_CHAN, LP_INF} loop_e;
    typedef enum logic [1:0] {U_SEC, U_MIN, U_HOUR} unit_e;
    typedef enum logic {ST_IDLE, ST_RUN} run_e;

    typedef struct packed {
        logic [15:0]        dur;
        unit_e              unit;
        logic               slope;
        logic signed [15:0] fin;
    } section_s;

    typedef struct packed {
        trig_e              trig;
        pause_e             pause;
        loop_e              loop;
        logic [2:0]         trigSrc;
        logic [2:0]         pauseSrc;
        logic [2:0]         loopSrc;
        logic signed [15:0] idle;
        logic [6:0]         secCount;
        logic [6:0]         restartIdx;
        logic [15:0]        loopCount;
        logic [4:0]         todH;
        logic [5:0]         todM;
        logic [5:0]         todS;
    } cfg_s;

    typedef struct packed {
        run_e               st;
        logic               paused;
        logic [6:0]         idx;
        logic [31:0]        elapsed;
        logic signed [15:0] prev;
        logic [15:0]        cycles;
        logic               trigPrev;
        logic               pausePrev;
        logic               todPrev;
        logic signed [15:0] out;
    } gen_s;
endpackage

// file: verilog/profile_if.sv
`timescale 1ns/100ps
interface profile_if;
    import profile_pkg::*;
    section_s           sec;
    logic [31:0]        elapsed;
    logic signed [15:0] prev;
    logic [31:0]        durTk;
    logic signed [15:0] value;
    modport hub    (output sec, output elapsed, output prev, input durTk, input value);
    modport shaper (input sec, input elapsed, input prev, output durTk, output value);
endinterface

// file: verilog/profile_shaper.sv
`timescale 1ns/100ps
module profile_shaper (
    // current section and position in, level out
    profile_if.shaper port
);
    import profile_pkg::*;

    logic signed [16:0] diff;
    logic signed [49:0] prod;
    logic signed [49:0] quot;

    always_comb begin
        unique case (port.sec.unit)
            U_MIN:   port.durTk = 32'(port.sec.dur) * TICKS_MIN;
            U_HOUR:  port.durTk = 32'(port.sec.dur) * TICKS_HOUR;
            default: port.durTk = 32'(port.sec.dur) * TICKS_SEC;
        endcase
        diff = 17'(port.sec.fin) - 17'(port.prev);
        prod = $signed({1'b0, port.elapsed}) * diff;
        // divider is wide but runs once per cycle; ramps are slow so area was traded for simplicity
        quot = (port.durTk == 32'h0) ? 50'sh0 : prod / $signed({18'h0, port.durTk});
        if (!port.sec.slope || port.durTk == 32'h0) begin
            port.value = port.sec.fin; // R23
        end else begin
            port.value = 16'(18'(port.prev) + 18'(quot)); // R22
        end
    end
endmodule

// file: verilog/profile_timer_generator.sv
// Operation
// R1 - eight independent generators, each with own configuration and run state
// R2 - gate mode: run only while trigger channel is above zero
// R3 - one-shot mode: rising trigger starts a run that then completes regardless
// R4 - retrigger mode: every rising trigger restarts from first section
// R5 - time-of-day mode starts at set time; disabled mode produces no profile
// R6 - pause disabled: pause channel ignored, never paused
// R7 - high-level pause: paused while pause channel above zero
// R8 - low-level pause: paused while pause channel zero or below
// R9 - level pause: triggers while paused are ignored
// R10 - level pause output: section 1 final if constant, else idle value
// R11 - rising-edge pause: each rising pause edge toggles paused
// R12 - falling-edge pause: each falling pause edge toggles paused
// R13 - edge pause: triggers act as if not paused
// R14 - idle value is output before and after a run
// R15 - up to one hundred sections, run in order
// R16 - no looping: one pass per trigger
// R17 - counted looping: repeat the configured number of times
// R18 - channel looping: stop once completed cycles reach channel value
// R19 - infinite looping: repeat without end
// R20 - repetitions after the first begin at the restart section
// R21 - section holds duration, unit, shape and final value
// R22 - slope ramps linearly from previous final to this final
// R23 - constant section settles within one tenth of a second
// R24 - edges found against previous sample on each evaluation tick
`timescale 1ns/100ps
module profile_timer_generator #(
    parameter int TICK_CYCLES = profile_pkg::TICK_CYC
) (
    // clock and reset
    input  logic                                         core_clk,
    input  logic                                         rst_n,
    // register port
    input  logic [profile_pkg::AW-1:0]                   addr,
    input  logic [profile_pkg::DW-1:0]                   wrData,
    input  logic                                         wrStb,
    input  logic                                         rdStb,
    output logic [profile_pkg::DW-1:0]                   rdData,
    // channel values and time of day
    input  logic [profile_pkg::NCH*profile_pkg::VW-1:0]  chanVal,
    input  logic [4:0]                                   todHour,
    input  logic [5:0]                                   todMin,
    input  logic [5:0]                                   todSec,
    // profile outputs
    output logic [profile_pkg::NGEN*profile_pkg::VW-1:0] profileOut,
    output logic [profile_pkg::NGEN-1:0]                 running,
    output logic [profile_pkg::NGEN-1:0]                 paused
);
    import profile_pkg::*;

    typedef struct packed {
        cfg_s     [NGEN-1:0]           cfg;
        section_s [NGEN-1:0][NSEC-1:0] mem;
        gen_s     [NGEN-1:0]           gen;
        logic     [23:0]               tickCnt;
        logic                          tick;
        logic     [DW-1:0]             rd;
    } state_s;

    state_s             s_q;
    state_s             s_d;
    logic [1:0]         rstPipe;
    logic               rstSyncN;
    logic [2:0]         secGen;
    logic [6:0]         secIdx;
    logic [2:0]         cfgGen;
    logic signed [15:0] trigV [NGEN];
    logic signed [15:0] pauseV [NGEN];
    logic signed [15:0] loopV [NGEN];
    logic [31:0]        durTk [NGEN];
    logic signed [15:0] shapeV [NGEN];
    cfg_s               c;
    gen_s               q;
    gen_s               n;
    section_s           cur;
    logic               tHi;
    logic               pHi;
    logic               rise;
    logic               todHit;
    logic               lvl;
    logic               start;
    logic               again;
    logic [15:0]        c1;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rstPipe <= 2'h0;
        end else begin
            rstPipe <= {rstPipe[0], 1'b1};
        end
    end
    assign rstSyncN = rstPipe[1];

    assign secGen = addr[SEC_GEN_LSB +: 3];
    assign secIdx = addr[SEC_IDX_LSB +: 7];
    assign cfgGen = addr[CFG_GEN_LSB +: 3];
    assign rdData = s_q.rd;

    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstSyncN);

    genvar g;
    generate
        for (g = 0; g < NGEN; g++) begin : gen_ch // R1
            profile_if pif ();
            assign trigV[g]      = chanVal[s_q.cfg[g].trigSrc * VW +: VW];
            assign pauseV[g]     = chanVal[s_q.cfg[g].pauseSrc * VW +: VW];
            assign loopV[g]      = chanVal[s_q.cfg[g].loopSrc * VW +: VW];
            assign pif.sec       = s_q.mem[g][s_q.gen[g].idx]; // R21
            assign pif.elapsed   = s_q.gen[g].elapsed;
            assign pif.prev      = s_q.gen[g].prev;
            assign durTk[g]      = pif.durTk;
            assign shapeV[g]     = pif.value;
            assign profileOut[g*VW +: VW] = s_q.gen[g].out;
            assign running[g]    = s_q.gen[g].st;
            assign paused[g]     = s_q.gen[g].paused;

            profile_shaper u_shaper (
                .port (pif.shaper)
            );

            a_gate_stop: assert property ( // R2
                s_q.tick && s_q.cfg[g].trig == TRG_GATE && trigV[g] <= 0
                |=> s_q.gen[g].st == ST_IDLE)
                else $error("gate run did not stop on low trigger");
            a_once_start: assert property ( // R3
                s_q.tick && s_q.cfg[g].trig == TRG_ONCE && trigV[g] > 0 && !s_q.gen[g].trigPrev
                && s_q.gen[g].st == ST_IDLE && s_q.cfg[g].pause == PS_OFF && s_q.cfg[g].secCount != 7'h0
                |=> s_q.gen[g].st == ST_RUN && s_q.gen[g].idx == 7'h0)
                else $error("one-shot edge did not start a run");
            a_retrig_restart: assert property ( // R4
                s_q.tick && s_q.cfg[g].trig == TRG_RETRIG && trigV[g] > 0 && !s_q.gen[g].trigPrev
                && s_q.cfg[g].pause == PS_OFF && s_q.cfg[g].secCount != 7'h0
                |=> s_q.gen[g].st == ST_RUN && s_q.gen[g].idx == 7'h0 && s_q.gen[g].elapsed == 32'h0)
                else $error("retrigger did not restart from first section");
            a_off_idle: assert property ( // R5
                s_q.cfg[g].trig == TRG_OFF |=> s_q.gen[g].st == ST_IDLE)
                else $error("disabled generator is running");
            a_pause_off: assert property ( // R6
                s_q.cfg[g].pause == PS_OFF |=> !s_q.gen[g].paused)
                else $error("paused with pause disabled");
            a_high_pause: assert property ( // R7
                s_q.tick && s_q.cfg[g].pause == PS_HIGH && pauseV[g] > 0 |=> s_q.gen[g].paused)
                else $error("high-level pause not taken");
            a_low_pause: assert property ( // R8
                s_q.tick && s_q.cfg[g].pause == PS_LOW && pauseV[g] <= 0 |=> s_q.gen[g].paused)
                else $error("low-level pause not taken");
            a_pause_blocks: assert property ( // R9
                s_q.tick && s_q.cfg[g].pause == PS_HIGH && pauseV[g] > 0 && s_q.gen[g].st == ST_IDLE
                |=> s_q.gen[g].st == ST_IDLE)
                else $error("trigger started a run while level paused");
            a_idle_out: assert property ( // R14
                s_q.gen[g].st == ST_IDLE |=> s_q.gen[g].out == $past(s_q.cfg[g].idle))
                else $error("idle value not on output");
        end
    endgenerate

    always_comb begin
        s_d = s_q;
        s_d.rd = RD_RST;
        c = '0;
        q = '0;
        n = '0;
        cur = '0;
        tHi = 1'b0;
        pHi = 1'b0;
        rise = 1'b0;
        todHit = 1'b0;
        lvl = 1'b0;
        start = 1'b0;
        again = 1'b0;
        c1 = 16'h0;

        // 0.1 s evaluation tick
        if (s_q.tickCnt == 24'(TICK_CYCLES - 1)) begin
            s_d.tickCnt = 24'h0;
            s_d.tick = 1'b1;
        end else begin
            s_d.tickCnt = s_q.tickCnt + 24'h1;
            s_d.tick = 1'b0;
        end

        if (wrStb) begin
            if (addr[SEC_BIT]) begin
                if (secIdx < NSEC) begin
                    if (addr[0]) begin
                        s_d.mem[secGen][secIdx].fin = wrData[15:0];
                    end else begin
                        s_d.mem[secGen][secIdx].dur = wrData[15:0]; // R21
                        s_d.mem[secGen][secIdx].unit = unit_e'(wrData[SEC_UNIT +: 2]);
                        s_d.mem[secGen][secIdx].slope = wrData[SEC_SLOPE];
                    end
                end
            end else if (addr[11:7] == 5'h0) begin
                case (addr[3:0])
                    REG_CTRL: begin
                        s_d.cfg[cfgGen].trig = trig_e'(wrData[CTL_TRIG +: 3]);
                        s_d.cfg[cfgGen].pause = pause_e'(wrData[CTL_PAUSE +: 3]);
                        s_d.cfg[cfgGen].loop = loop_e'(wrData[CTL_LOOP +: 2]);
                        s_d.cfg[cfgGen].trigSrc = wrData[CTL_TSRC +: 3];
                        s_d.cfg[cfgGen].pauseSrc = wrData[CTL_PSRC +: 3];
                        s_d.cfg[cfgGen].loopSrc = wrData[CTL_LSRC +: 3];
                    end
                    REG_IDLE: s_d.cfg[cfgGen].idle = wrData[15:0];
                    REG_LIST: begin
                        // count above the list size is clamped so the section index stays in range
                        s_d.cfg[cfgGen].secCount = (wrData[6:0] > NSEC) ? 7'(NSEC) : wrData[6:0]; // R15
                        s_d.cfg[cfgGen].restartIdx = wrData[LST_RST +: 7];
                    end
                    REG_LOOPS: s_d.cfg[cfgGen].loopCount = wrData[15:0];
                    REG_TOD: begin
                        s_d.cfg[cfgGen].todS = wrData[5:0];
                        s_d.cfg[cfgGen].todM = wrData[TOD_MIN +: 6];
                        s_d.cfg[cfgGen].todH = wrData[TOD_HOUR +: 5];
                    end
                    default: ;
                endcase
            end
        end

        if (rdStb) begin
            if (addr[SEC_BIT]) begin
                if (secIdx < NSEC) begin
                    if (addr[0]) begin
                        s_d.rd[15:0] = s_q.mem[secGen][secIdx].fin;
                    end else begin
                        s_d.rd[15:0] = s_q.mem[secGen][secIdx].dur;
                        s_d.rd[SEC_UNIT +: 2] = s_q.mem[secGen][secIdx].unit;
                        s_d.rd[SEC_SLOPE] = s_q.mem[secGen][secIdx].slope;
                    end
                end
            end else if (addr[11:7] == 5'h0) begin
                case (addr[3:0])
                    REG_CTRL: begin
                        s_d.rd[CTL_TRIG +: 3] = s_q.cfg[cfgGen].trig;
                        s_d.rd[CTL_PAUSE +: 3] = s_q.cfg[cfgGen].pause;
                        s_d.rd[CTL_LOOP +: 2] = s_q.cfg[cfgGen].loop;
                        s_d.rd[CTL_TSRC +: 3] = s_q.cfg[cfgGen].trigSrc;
                        s_d.rd[CTL_PSRC +: 3] = s_q.cfg[cfgGen].pauseSrc;
                        s_d.rd[CTL_LSRC +: 3] = s_q.cfg[cfgGen].loopSrc;
                    end
                    REG_IDLE: s_d.rd[15:0] = s_q.cfg[cfgGen].idle;
                    REG_LIST: begin
                        s_d.rd[6:0] = s_q.cfg[cfgGen].secCount;
                        s_d.rd[LST_RST +: 7] = s_q.cfg[cfgGen].restartIdx;
                    end
                    REG_LOOPS: s_d.rd[15:0] = s_q.cfg[cfgGen].loopCount;
                    REG_TOD: begin
                        s_d.rd[5:0] = s_q.cfg[cfgGen].todS;
                        s_d.rd[TOD_MIN +: 6] = s_q.cfg[cfgGen].todM;
                        s_d.rd[TOD_HOUR +: 5] = s_q.cfg[cfgGen].todH;
                    end
                    REG_STATUS: begin
                        s_d.rd[0] = s_q.gen[cfgGen].st;
                        s_d.rd[STA_PAUSE] = s_q.gen[cfgGen].paused;
                        s_d.rd[STA_IDX +: 7] = s_q.gen[cfgGen].idx;
                        s_d.rd[STA_CYC +: 16] = s_q.gen[cfgGen].cycles;
                    end
                    REG_OUT: s_d.rd[15:0] = s_q.gen[cfgGen].out;
                    default: ;
                endcase
            end
        end

        for (int i = 0; i < NGEN; i++) begin // R1
            c = s_q.cfg[i];
            q = s_q.gen[i];
            n = q;
            cur = s_q.mem[i][q.idx];
            tHi = trigV[i] > 0;
            pHi = pauseV[i] > 0;
            todHit = {todHour, todMin, todSec} == {c.todH, c.todM, c.todS};
            lvl = 1'b0;
            start = 1'b0;
            again = 1'b0;
            c1 = q.cycles + 16'h1;
            if (s_q.tick) begin
                n.trigPrev = tHi; // R24
                n.pausePrev = pHi; // R24
                n.todPrev = todHit;
                unique case (c.pause)
                    PS_OFF: n.paused = 1'b0; // R6
                    PS_HIGH: n.paused = pHi; // R7
                    PS_LOW: n.paused = !pHi; // R8
                    PS_RISE: if (pHi && !q.pausePrev) n.paused = !q.paused; // R11
                    PS_FALL: if (!pHi && q.pausePrev) n.paused = !q.paused; // R12
                    default: n.paused = 1'b0;
                endcase
                lvl = n.paused && (c.pause == PS_HIGH || c.pause == PS_LOW);
                rise = tHi && !q.trigPrev; // R24
                unique case (c.trig)
                    TRG_GATE: start = rise; // R2
                    TRG_RETRIG: start = rise; // R4
                    TRG_ONCE: start = rise && q.st == ST_IDLE; // R3
                    TRG_TOD: start = todHit && !q.todPrev && q.st == ST_IDLE; // R5
                    default: start = 1'b0;
                endcase
                if (c.trig == TRG_GATE && !tHi) begin
                    n.st = ST_IDLE; // R2
                end
                if (start && !lvl && c.secCount != 7'h0) begin // R9
                    n.st = ST_RUN;
                    n.idx = 7'h0;
                    n.elapsed = 32'h0;
                    n.prev = c.idle;
                    n.cycles = 16'h0;
                    if (c.pause == PS_RISE || c.pause == PS_FALL) begin
                        n.paused = 1'b0; // R13
                    end
                end else if (n.st == ST_RUN && !n.paused) begin
                    if (q.elapsed + 32'h1 >= durTk[i]) begin
                        n.prev = cur.fin; // R22
                        n.elapsed = 32'h0;
                        if (q.idx + 7'h1 >= c.secCount) begin
                            n.cycles = c1;
                            unique case (c.loop)
                                LP_OFF: again = 1'b0; // R16
                                LP_COUNT: again = c1 < c.loopCount; // R17
                                LP_CHAN: again = $signed({1'b0, c1}) < $signed({loopV[i][15], loopV[i]}); // R18
                                LP_INF: again = 1'b1; // R19
                            endcase
                            if (again) begin
                                n.idx = (c.restartIdx < c.secCount) ? c.restartIdx : 7'h0; // R20
                            end else begin
                                n.st = ST_IDLE;
                            end
                        end else begin
                            n.idx = q.idx + 7'h1; // R15
                        end
                    end else begin
                        n.elapsed = q.elapsed + 32'h1;
                    end
                end
            end
            if (c.trig == TRG_OFF) begin
                n.st = ST_IDLE; // R5
            end
            if (c.pause == PS_OFF) begin
                n.paused = 1'b0; // R6
            end
            if (q.st == ST_IDLE) begin
                n.out = c.idle; // R14
            end else if (q.paused && (c.pause == PS_HIGH || c.pause == PS_LOW)) begin
                n.out = s_q.mem[i][0].slope ? c.idle : s_q.mem[i][0].fin; // R10
            end else begin
                n.out = shapeV[i]; // R22 R23
            end
            s_d.gen[i] = n;
        end
    end

    always_ff @(posedge core_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
endmodule

// file: dv/chan_model.sv
`timescale 1ns/100ps
module chan_model (
    // per-channel levels set by the bench
    input  logic [profile_pkg::VW-1:0]              level [profile_pkg::NCH],
    // packed channel bus seen by the generators
    output logic [profile_pkg::NCH*profile_pkg::VW-1:0] chanVal
);
    import profile_pkg::*;
    // channels are plain levels; the bench changes them only at clock edges
    always_comb begin
        for (int k = 0; k < NCH; k++) chanVal[k*VW +: VW] = level[k];
    end
endmodule

// file: dv/profile_timer_generator_bench.sv
`timescale 1ns/100ps
module profile_timer_generator_bench;
    import profile_pkg::*;
    localparam int TK = 4;
    logic               core_clk = 1'b0;
    logic               rst_n    = 1'b0;
    logic [AW-1:0]      addr     = '0;
    logic [DW-1:0]      wrData   = '0;
    logic               wrStb    = 1'b0;
    logic               rdStb    = 1'b0;
    logic [DW-1:0]      rdData;
    logic [VW-1:0]      level [NCH] = '{default: '0};
    logic [NCH*VW-1:0]  chanVal;
    logic [NGEN*VW-1:0] profileOut;
    logic [NGEN-1:0]    running;
    logic [NGEN-1:0]    paused;
    int                 fail_count = 0;
    int                 checks     = 0;
    int                 n;
    logic [5:0]         todS       = 6'h0;

    always #5 core_clk = ~core_clk;

    chan_model CH (.level(level), .chanVal(chanVal));
    // only the seconds of the time of day move; hour and minute stay at midnight
    profile_timer_generator #(.TICK_CYCLES(TK)) DUT (
        .core_clk(core_clk), .rst_n(rst_n), .addr(addr), .wrData(wrData), .wrStb(wrStb),
        .rdStb(rdStb), .rdData(rdData), .chanVal(chanVal), .todHour(5'h0), .todMin(6'h0),
        .todSec(todS), .profileOut(profileOut), .running(running), .paused(paused));

    task automatic tally_and_finish();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input string what, input logic [DW-1:0] seen, input logic [DW-1:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // strobe then a quiet cycle, so back-to-back calls never assign a strobe twice at one edge
    task automatic wr(input int a, input logic [DW-1:0] d);
        addr   <= a[AW-1:0];
        wrData <= d;
        wrStb  <= 1'b1;
        @(posedge core_clk);
        wrStb  <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic rd(input int a, input logic [DW-1:0] exp, input string what);
        addr  <= a[AW-1:0];
        rdStb <= 1'b1;
        @(posedge core_clk);
        rdStb <= 1'b0;
        #1;
        chk(what, rdData, exp);
        @(posedge core_clk);
    endtask

    // waits for generator 0 to start, returns its run length in cycles
    task automatic run_len(input logic [VW-1:0] fin, input logic [VW-1:0] idle, output int len);
        len = 0;
        for (int i = 0; i < 400 && running[0] !== 1'b1; i++) @(posedge core_clk) #1;
        while (running[0] === 1'b1 && len < 2000) begin
            @(posedge core_clk) #1;
            len++;
            if (len == 1) chk("out run", 32'(profileOut[VW-1:0]), 32'(fin));
        end
        @(posedge core_clk) #1;
        chk("out after", 32'(profileOut[VW-1:0]), 32'(idle));
        @(posedge core_clk);
    endtask

    initial begin
        #400000;
        fail_count++;
        tally_and_finish();
    end

    initial begin
        repeat (4) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        #1;
        chk("out reset", 32'(profileOut != '0), 32'h0);
        chk("flags reset", 32'({running, paused}), 32'h0);
        @(posedge core_clk);
        wr(1, 32'h5);
        wr(2, 32'h1);
        wr(4096, 32'h1);
        wr(4097, 32'h64);
        rd(1, 32'h5, "idle reg");
        rd(7, 32'h0, "unmapped");
        wr(0, 32'h2);
        rd(6, 32'h5, "out reg");
        level[0] <= 16'h1;
        run_len(16'h64, 16'h5, n);
        chk("once len", n, 10 * TK);
        repeat (3 * TK) @(posedge core_clk);
        #1;
        chk("no rerun", 32'(running[0]), 32'h0);
        wr(3, 32'h3);
        wr(0, 32'h102);
        level[0] <= 16'h0;
        repeat (2 * TK) @(posedge core_clk);
        level[0] <= 16'h1;
        run_len(16'h64, 16'h5, n);
        chk("count len", n, 30 * TK);
        wr(0, 32'h20012);
        level[0] <= 16'h0;
        level[2] <= 16'h1;
        repeat (3 * TK) @(posedge core_clk);
        level[0] <= 16'h1;
        repeat (3 * TK) @(posedge core_clk);
        #1;
        chk("held run", 32'(running[0]), 32'h0);
        chk("held flag", 32'(paused[0]), 32'h1);
        // no run yet, so the idle value stands; the section rule applies to a paused run
        chk("held out", 32'(profileOut[VW-1:0]), 32'h5);
        @(posedge core_clk);
        level[2] <= 16'hffff;
        repeat (3 * TK) @(posedge core_clk);
        #1;
        chk("resumed", 32'(paused[0]), 32'h0);
        @(posedge core_clk);
        // a second section with its own level shows which final value a pause forces
        wr(4098, 32'h1);
        wr(4099, 32'h20);
        wr(2, 32'h2);
        level[0] <= 16'h0;
        repeat (2 * TK) @(posedge core_clk);
        level[0] <= 16'h1;
        repeat (14 * TK) @(posedge core_clk);
        level[2] <= 16'h1;
        repeat (2 * TK) @(posedge core_clk);
        #1;
        chk("pause run", 32'({running[0], paused[0]}), 32'h3);
        chk("pause out", 32'(profileOut[VW-1:0]), 32'h64);
        @(posedge core_clk);
        level[2] <= 16'h0;
        repeat (12 * TK) @(posedge core_clk);
        #1;
        chk("pass done", 32'(running[0]), 32'h0);
        @(posedge core_clk);
        wr(4, 32'h3);
        wr(0, 32'h4);
        repeat (TK) @(posedge core_clk);
        todS <= 6'h3;
        run_len(16'h64, 16'h5, n);
        chk("tod len", n, 20 * TK);
        wr(0, 32'h0);
        #1;
        chk("off out", 32'(profileOut[VW-1:0]), 32'h5);
        chk("off run", 32'(running[0]), 32'h0);
        tally_and_finish();
    end
endmodule
